// file: logic/adsp_config_bank.sv
// Audio DSP configuration bank: processing registers and the selections they drive.
//
// Functional notes
// RL1: While the converter is powered and the volume lock bit is set, volume codes are frozen.
// RL2: The enhanced-algorithm bit chooses enhanced over standard level-control algorithms.
// RL3: The decimator response field picks linear, low or ultra-low latency; 3 is reserved.
// RL4: Averaging field 1 outputs (ch1 + ch2) / 2, 0 disables it, 2 and 3 are reserved.
// RL5: High-pass choice 0 selects the programmable first-order IIR filter.
// RL6: High-pass choice 1, 2, 3 selects fixed cutoffs of 0.00025, 0.002, 0.008 fs; reset is 1.
// RL7: Volume gang makes every active channel use the first channel volume.
// RL8: The biquad count field enables 0 to 3 stages per channel and resets to two.
// RL9: Volume changes, mute and unmute are soft-stepped unless soft-step disable is set.
// RL10: Without compression, an enabled channel runs the range enhancer or AGC by the select bit.
// RL11: Compression enable runs the compressor and excludes range enhancer and AGC.
// RL12: Anti-clip compresses when gain is above 0 dB and a level mode is active.
// RL13: Software writes only zero to the reserved bit 2 of the second config register.
// RL14: Volume code 0 mutes, code 1 is -100 dB, code 201 is 0 dB, in 0.5 dB steps.
// RL15: Each field holds its written value, reads it back, and resets to its reset value.
`timescale 1ns/1ns
module adsp_config_bank
  import adsp_pkg::*;
#(
  parameter int NCH = 4,
  parameter logic [6:0] DEV_ADDR = 7'h4e
) (
  input wire logic i_ref_clk, // Device clock, 250 MHz.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_clk_en, // Freezes all state while low.
  input wire logic i_scl, // Control interface serial clock.
  input wire logic i_sda, // Control interface serial data in.
  output logic o_sda_out, // Serial data drive value.
  output logic o_sda_oe, // Serial data pull-down enable.
  input wire logic i_converter_powered, // Converter is powered on.
  input wire logic [NCH-1:0][7:0] i_per_channel_volume, // Volume codes, index 0 is channel one.
  input wire logic [NCH-1:0] i_channel_range_enhancer_enable, // Per-channel enable.
  input wire logic [NCH-1:0] i_gain_above_0db, // Channel gain is above 0 dB.
  output adsp_cfg_a_t o_cfg_a, // First processing config register.
  output adsp_cfg_b_t o_cfg_b, // Second processing config register.
  output logic [7:0] o_range_enhancer_config, // Range enhancer threshold and gain.
  output adsp_decim_t o_decim_sel, // Decimator response in use.
  output logic o_channel_average_en, // Output (ch1 + ch2) / 2.
  output logic o_hpf_programmable, // Programmable IIR high-pass in use.
  output logic [1:0] o_hpf_cutoff_sel, // Fixed high-pass cutoff choice, 0 when programmable.
  output logic o_enhanced_algos, // Enhanced level algorithms.
  output logic [ADSP_BIQUAD_MAX-1:0] o_biquad_stage_en, // Biquad stage enables.
  output logic o_soft_step_en, // Soft-step volume changes.
  output logic o_compressor_run, // Range compressor active.
  output logic [NCH-1:0] o_range_enhancer_run, // Range enhancer active per channel.
  output logic [NCH-1:0] o_agc_run, // AGC active per channel.
  output logic [NCH-1:0] o_anti_clip_run, // Anti-clip compression armed per channel.
  output adsp_vol_t [NCH-1:0] o_volume // Effective volume per channel.
);

  if (NCH < 2 || NCH > 8) begin : g_chk
    $error("adsp_config_bank: NCH must be 2 to 8");
  end

  // Both ends of the 7-bit address space are set aside on the bus for special transfers.
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_chk_addr
    $error("adsp_config_bank: DEV_ADDR lies in a reserved bus address range");
  end

  // The stage enables are decoded from a two-bit count, which can name at most three stages.
  if (ADSP_BIQUAD_MAX != 3) begin : g_chk_bq
    $error("adsp_config_bank: the biquad count field serves exactly three stages");
  end

  typedef enum logic [1:0] {
    REG_A = 2'b00,
    REG_B = 2'b01,
    REG_RE = 2'b10,
    REG_NONE = 2'b11
  } adsp_reg_sel_t;

  typedef struct packed {
    adsp_cfg_a_t cfg_a;
    adsp_cfg_b_t cfg_b;
    logic [7:0] re_cfg;
    adsp_vol_t [NCH-1:0] vol;
    logic [NCH-1:0] re_run;
    logic [NCH-1:0] agc_run;
    logic [NCH-1:0] clip_run;
  } adsp_bank_state_t;

  adsp_bank_state_t s_r;
  adsp_bank_state_t s_nxt;
  adsp_regwr_t regwr;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic vol_update;

  // The read mux and the write path share one decode.
  // Keeping a single copy means the two can never disagree about the register map.
  function automatic adsp_reg_sel_t decode(input logic [7:0] addr);
    if (addr == ADSP_OFS_CFG_A) begin
      decode = REG_A;
    end else if (addr == ADSP_OFS_CFG_B) begin
      decode = REG_B;
    end else if (addr == ADSP_OFS_RE_CFG) begin
      decode = REG_RE;
    end else begin
      decode = REG_NONE;
    end
  endfunction

  // Gain is kept in half decibels relative to unity, and the mute code is flagged apart.
  function automatic adsp_vol_t vol_map(input logic [7:0] code);
    vol_map.mute = (code == ADSP_VOL_MUTE_CODE); // RL14
    vol_map.gain_half_db = $signed({1'b0, code}) - $signed(ADSP_VOL_ZERO_DB_CODE); // RL14
  endfunction

  // One decode serves every channel, so the three run flags cannot disagree about the mode.
  function automatic logic [2:0] level_run(input adsp_cfg_b_t cfg, input logic ch_en,
                                           input logic gain_hi);
    logic mode_re;
    logic mode_agc;
    logic mode_clip;
    mode_re = !cfg.compression_enable && ch_en && !cfg.level_algorithm_select; // RL10
    mode_agc = !cfg.compression_enable && ch_en && cfg.level_algorithm_select; // RL10 RL11
    mode_clip = cfg.anti_clip_enable && gain_hi && (cfg.compression_enable || ch_en); // RL12
    level_run = {mode_re, mode_agc, mode_clip};
  endfunction

  // The serial engine owns all bus timing; this level only sees whole-byte writes and reads.
  adsp_i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_rd_addr(rd_addr),
    .i_rdata(rdata),
    .o_regwr(regwr)
  );

  // Unmapped offsets read as zero, so a host probing the map always sees a defined value.
  // The mux is combinational because the serial engine samples it at the serial clock fall after the pointer moves.
  always_comb begin
    case (decode(rd_addr))
      REG_A: rdata = s_r.cfg_a; // RL15
      REG_B: rdata = s_r.cfg_b; // RL15
      REG_RE: rdata = s_r.re_cfg;
      default: rdata = ADSP_RDATA_UNMAPPED;
    endcase
  end

  // Locking while powered keeps multichannel processing at high rates free of volume updates.
  // Volumes still track their inputs while the converter is off, so unlocking needs no resync.
  assign vol_update = !i_converter_powered || !s_r.cfg_a.runtime_volume_lock; // RL1

  // A write to an unmapped offset is dropped; the explicit default keeps the case complete.
  always_comb begin
    s_nxt = s_r;
    if (regwr.wr) begin
      case (decode(regwr.addr))
        REG_A: s_nxt.cfg_a = regwr.wdata; // RL15
        REG_B: s_nxt.cfg_b = regwr.wdata; // RL13
        REG_RE: s_nxt.re_cfg = regwr.wdata;
        default: s_nxt.re_cfg = s_r.re_cfg;
      endcase
    end
    for (int ch = 0; ch < NCH; ch++) begin
      if (vol_update) begin
        // Gang mode follows the first channel even while that channel is powered down.
        if (s_r.cfg_b.volume_gang) begin
          s_nxt.vol[ch] = vol_map(i_per_channel_volume[0]); // RL7
        end else begin
          s_nxt.vol[ch] = vol_map(i_per_channel_volume[ch]); // RL7
        end
      end
      // Run flags are registered to keep the mode decode off the output paths.
      {s_nxt.re_run[ch], s_nxt.agc_run[ch], s_nxt.clip_run[ch]} =
        level_run(s_r.cfg_b, i_channel_range_enhancer_enable[ch], i_gain_above_0db[ch]);
    end
  end

  // Only the three registers reset to non-zero values.
  // Run flags and volumes start cleared and settle one enabled cycle after release.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.cfg_a <= ADSP_RST_CFG_A; // RL15
      s_r.cfg_b <= ADSP_RST_CFG_B; // RL8
      s_r.re_cfg <= ADSP_RST_RE_CFG;
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Stage enables form a thermometer code, so a stage runs only when all lower stages run.
  for (genvar i = 0; i < ADSP_BIQUAD_MAX; i++) begin : g_biquad
    assign o_biquad_stage_en[i] = (s_r.cfg_b.biquad_count > 2'(i)); // RL8
  end

  // Selections are decoded combinationally from the stored fields; the per-channel run flags are read from their own registers.
  // The selections therefore follow a register write in the same cycle as the register outputs, and the run flags one cycle later.
  assign o_cfg_a = s_r.cfg_a;
  assign o_cfg_b = s_r.cfg_b;
  assign o_range_enhancer_config = s_r.re_cfg;
  // The reserved response code falls back to linear phase rather than an undefined filter.
  assign o_decim_sel = (s_r.cfg_a.decimator_response_sel == ADSP_DECIM_RSVD) ?
    ADSP_DECIM_LINEAR : s_r.cfg_a.decimator_response_sel; // RL3
  assign o_channel_average_en = (s_r.cfg_a.channel_average_mode == 2'b01); // RL4
  assign o_hpf_programmable = (s_r.cfg_a.highpass_choice == 2'b00); // RL5
  // The cutoff choice is passed raw; it reads zero whenever the programmable filter is chosen.
  assign o_hpf_cutoff_sel = s_r.cfg_a.highpass_choice; // RL6
  assign o_enhanced_algos = s_r.cfg_a.enhanced_level_algorithms; // RL2
  assign o_soft_step_en = !s_r.cfg_b.soft_step_disable; // RL9
  assign o_compressor_run = s_r.cfg_b.compression_enable; // RL11
  assign o_range_enhancer_run = s_r.re_run;
  assign o_agc_run = s_r.agc_run;
  assign o_anti_clip_run = s_r.clip_run;
  assign o_volume = s_r.vol;

endmodule

// file: logic/adsp_i2c_target.sv
// I2C target engine that turns bus transfers into register pointer reads and writes.
`timescale 1ns/1ns
module adsp_i2c_target
  import adsp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h4e
) (
  input wire logic i_ref_clk, // Device clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_clk_en, // Freezes all state while low.
  input wire logic i_scl, // Serial clock level.
  input wire logic i_sda, // Serial data level.
  output logic o_sda_out, // Serial data drive value, always low.
  output logic o_sda_oe, // High while pulling serial data low.
  output logic [7:0] o_rd_addr, // Register pointer for reads.
  input wire logic [7:0] i_rdata, // Read data at the pointer.
  output adsp_regwr_t o_regwr // Write pulse with address and data.
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WR = 3'b011,
    ST_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RACK = 3'b110
  } adsp_i2c_st_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    adsp_i2c_st_t st;
    adsp_i2c_st_t ack_next;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic acked;
    logic sda_oe;
    adsp_regwr_t regwr;
  } adsp_i2c_state_t;

  adsp_i2c_state_t s_r;
  adsp_i2c_state_t s_nxt;

  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  assign rise = !s_r.scl_q && i_scl;
  assign fall = s_r.scl_q && !i_scl;
  assign start_c = s_r.scl_q && i_scl && s_r.sda_q && !i_sda;
  assign stop_c = s_r.scl_q && i_scl && !s_r.sda_q && i_sda;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q = i_scl;
    s_nxt.sda_q = i_sda;
    s_nxt.regwr.wr = 1'b0;
    if (start_c) begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        ST_ADDR, ST_REG, ST_WR: begin
          if (rise && s_r.bitcnt != 4'h8) begin
            s_nxt.shreg = {s_r.shreg[6:0], i_sda};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end else if (fall && s_r.bitcnt == 4'h8) begin
            s_nxt.st = ST_ACK;
            s_nxt.sda_oe = 1'b1;
            if (s_r.st == ST_ADDR) begin
              s_nxt.ack_next = s_r.shreg[0] ? ST_RD : ST_REG;
              if (s_r.shreg[7:1] != DEV_ADDR) begin
                s_nxt.st = ST_IDLE;
                s_nxt.sda_oe = 1'b0;
              end
            end else if (s_r.st == ST_REG) begin
              s_nxt.ptr = s_r.shreg;
              s_nxt.ack_next = ST_WR;
            end else begin
              s_nxt.regwr.wr = 1'b1;
              s_nxt.regwr.addr = s_r.ptr;
              s_nxt.regwr.wdata = s_r.shreg;
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            s_nxt.st = s_r.ack_next;
            s_nxt.bitcnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
            if (s_r.ack_next == ST_RD) begin
              s_nxt.sda_oe = !i_rdata[7];
              s_nxt.shreg = {i_rdata[6:0], 1'b0};
              s_nxt.bitcnt = 4'h1;
            end
          end
        end
        ST_RD: begin
          if (fall) begin
            if (s_r.bitcnt == 4'h8) begin
              s_nxt.st = ST_RACK;
              s_nxt.sda_oe = 1'b0;
              s_nxt.acked = 1'b0;
            end else begin
              s_nxt.sda_oe = !s_r.shreg[7];
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            // A controller that does not acknowledge ends the read burst.
            if (i_sda) begin
              s_nxt.st = ST_IDLE;
            end else begin
              s_nxt.acked = 1'b1;
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
          end else if (fall && s_r.acked) begin
            s_nxt.st = ST_RD;
            s_nxt.sda_oe = !i_rdata[7];
            s_nxt.shreg = {i_rdata[6:0], 1'b0};
            s_nxt.bitcnt = 4'h1;
          end
        end
        default: begin
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{scl_q: 1'b1, sda_q: 1'b1, st: ST_IDLE, ack_next: ST_IDLE, bitcnt: 4'h0,
               shreg: 8'h00, ptr: 8'h00, acked: 1'b0, sda_oe: 1'b0,
               regwr: '{wr: 1'b0, addr: 8'h00, wdata: 8'h00}};
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = s_r.sda_oe;
  assign o_rd_addr = s_r.ptr;
  assign o_regwr = s_r.regwr;

endmodule

// file: logic/adsp_pkg.sv
// Package with register map, field layouts and reset values of the audio DSP config bank.
package adsp_pkg;

  localparam logic [7:0] ADSP_OFS_CFG_A = 8'h6b;
  localparam logic [7:0] ADSP_OFS_CFG_B = 8'h6c;
  localparam logic [7:0] ADSP_OFS_RE_CFG = 8'h6d;

  localparam logic [7:0] ADSP_RST_CFG_A = 8'h01;
  localparam logic [7:0] ADSP_RST_CFG_B = 8'h40;
  localparam logic [7:0] ADSP_RST_RE_CFG = 8'h7b;
  localparam logic [7:0] ADSP_RDATA_UNMAPPED = 8'h00;

  localparam logic [7:0] ADSP_VOL_MUTE_CODE = 8'h00;
  localparam logic [8:0] ADSP_VOL_ZERO_DB_CODE = 9'h0c9;
  localparam int ADSP_BIQUAD_MAX = 3;

  typedef enum logic [1:0] {
    ADSP_DECIM_LINEAR = 2'b00,
    ADSP_DECIM_LOW_LAT = 2'b01,
    ADSP_DECIM_ULTRA_LOW = 2'b10,
    ADSP_DECIM_RSVD = 2'b11
  } adsp_decim_t;

  // Field order gives the bit positions, most significant first.
  typedef struct packed {
    logic runtime_volume_lock;
    logic enhanced_level_algorithms;
    adsp_decim_t decimator_response_sel;
    logic [1:0] channel_average_mode;
    logic [1:0] highpass_choice;
  } adsp_cfg_a_t;

  typedef struct packed {
    logic volume_gang;
    logic [1:0] biquad_count;
    logic soft_step_disable;
    logic level_algorithm_select;
    logic reserved_bit;
    logic compression_enable;
    logic anti_clip_enable;
  } adsp_cfg_b_t;

  typedef struct packed {
    logic mute;
    logic signed [8:0] gain_half_db;
  } adsp_vol_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adsp_regwr_t;

endpackage

// file: tb/adsp_config_bank_monitor.sv
// Checker tying the bank's selections and run flags to its stored fields.
`timescale 1ns/1ns
module adsp_config_bank_monitor
  import adsp_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic i_ref_clk, // Device clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic i_converter_powered, // Converter on.
  input wire logic [NCH-1:0] i_channel_range_enhancer_enable, // Channel enables.
  input wire logic [NCH-1:0] i_gain_above_0db, // Gain flags.
  input wire adsp_cfg_a_t o_cfg_a, // First config register.
  input wire adsp_cfg_b_t o_cfg_b, // Second config register.
  input wire adsp_decim_t o_decim_sel, // Decimator in use.
  input wire logic o_channel_average_en, // Averaging on.
  input wire logic o_hpf_programmable, // Programmable high-pass.
  input wire logic [1:0] o_hpf_cutoff_sel, // Fixed cutoff choice.
  input wire logic o_enhanced_algos, // Enhanced algorithms.
  input wire logic [ADSP_BIQUAD_MAX-1:0] o_biquad_stage_en, // Stage enables.
  input wire logic o_soft_step_en, // Soft stepping.
  input wire logic o_compressor_run, // Compressor on.
  input wire logic [NCH-1:0] o_range_enhancer_run, // Enhancer per channel.
  input wire logic [NCH-1:0] o_agc_run, // AGC per channel.
  input wire logic [NCH-1:0] o_anti_clip_run, // Anti-clip per channel.
  input wire adsp_vol_t [NCH-1:0] o_volume // Effective volume.
);
  wire logic cmp = o_cfg_b.compression_enable;
  wire logic sel = o_cfg_b.level_algorithm_select;
  wire logic [1:0] bq = o_cfg_b.biquad_count;
  wire logic [1:0] hp = o_cfg_a.highpass_choice;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_decim;
    o_decim_sel == ((o_cfg_a.decimator_response_sel == ADSP_DECIM_RSVD) ? ADSP_DECIM_LINEAR
      : o_cfg_a.decimator_response_sel);
  endproperty
  a_decim: assert property (p_decim) else $error("decimator select wrong");
  property p_avg;
    o_channel_average_en == (o_cfg_a.channel_average_mode == 2'h1);
  endproperty
  a_avg: assert property (p_avg) else $error("averaging enable wrong");
  property p_hpf;
    o_hpf_programmable == (hp == 2'h0) && o_hpf_cutoff_sel == hp;
  endproperty
  a_hpf: assert property (p_hpf) else $error("high-pass choice wrong");
  property p_biquad;
    o_biquad_stage_en == {bq > 2'h2, bq > 2'h1, bq > 2'h0};
  endproperty
  a_biquad: assert property (p_biquad) else $error("biquad stages wrong");
  property p_flags;
    o_enhanced_algos == o_cfg_a.enhanced_level_algorithms &&
      o_soft_step_en != o_cfg_b.soft_step_disable && o_compressor_run == cmp;
  endproperty
  a_flags: assert property (p_flags) else $error("mode flags wrong");
  property p_re;
    $past(i_rst_n) |-> o_range_enhancer_run ==
      $past(i_channel_range_enhancer_enable & {NCH{!cmp && !sel}});
  endproperty
  a_re: assert property (p_re) else $error("range enhancer run wrong");
  property p_agc;
    $past(i_rst_n) |-> o_agc_run == $past(i_channel_range_enhancer_enable & {NCH{!cmp && sel}});
  endproperty
  a_agc: assert property (p_agc) else $error("agc run wrong");
  property p_anti;
    $past(i_rst_n) |-> o_anti_clip_run == $past(i_gain_above_0db &
      ({NCH{cmp}} | i_channel_range_enhancer_enable) & {NCH{o_cfg_b.anti_clip_enable}});
  endproperty
  a_anti: assert property (p_anti) else $error("anti-clip run wrong");
  property p_lock;
    i_converter_powered && o_cfg_a.runtime_volume_lock |=> $stable(o_volume);
  endproperty
  a_lock: assert property (p_lock) else $error("volume changed while locked");
  property p_gang;
    $past(i_rst_n) && $past(o_cfg_b.volume_gang) &&
      !$past(i_converter_powered && o_cfg_a.runtime_volume_lock) |-> o_volume[NCH-1] == o_volume[0];
  endproperty
  a_gang: assert property (p_gang) else $error("ganged volume differs");
endmodule

// file: tb/adsp_host_model.sv
// Controller model that reaches the bank over the two-wire control bus.
`timescale 1ns/1ns
module adsp_host_model (
  input wire logic i_ref_clk, // Paces the bus.
  input wire logic i_sda_oe, // Device pulls data low.
  output logic o_scl, // Serial clock.
  output logic o_sda // Data level, pulled up.
);
  logic drv = 1'b1;
  initial o_scl = 1'b1;
  // Either party may pull low; the pull-up wins otherwise, so a released line reads high.
  assign o_sda = drv & ~i_sda_oe;
  // Four cycles per phase keeps every edge well apart; data moves while the clock is low, except in the start and stop conditions.
  task automatic s(input logic c, input logic d);
    o_scl = c;
    drv = d;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    s(1'b0, b);
    s(1'b1, b);
    r = o_sda;
    s(1'b0, b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(a, n);
  endtask
  task automatic start;
    s(1'b0, 1'b1);
    s(1'b1, 1'b1);
    s(1'b1, 1'b0);
    s(1'b0, 1'b0);
  endtask
  task automatic stop;
    s(1'b0, 1'b0);
    s(1'b1, 1'b0);
    s(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic n1, n2, n3;
    start;
    xfer({dev, 1'b0}, 1'b1, r, n1);
    xfer(a, 1'b1, r, n2);
    xfer(d, 1'b1, r, n3);
    stop;
    nak = n1 | n2 | n3;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
    logic n;
    start;
    xfer({dev, 1'b0}, 1'b1, d, n);
    xfer(a, 1'b1, d, n);
    start;
    xfer({dev, 1'b1}, 1'b1, d, n);
    xfer(8'hff, 1'b1, d, n);
    stop;
  endtask
endmodule

// file: tb/audio_dsp_config_bank_test.sv
// Self-checking bench: register access, run flags, volume handling and reset.
`timescale 1ns/1ns
module audio_dsp_config_bank_test;
  import adsp_pkg::*;
  localparam int NCH = 4;
  localparam logic [6:0] DEV = 7'h4e;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rb;} adsp_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr = 1'b0;
  logic ce = 1'b1;
  logic [NCH-1:0][7:0] vol = '0;
  logic [NCH-1:0] re_en = '0, gain = '0, re_run, agc_run, ac_run;
  logic scl, sda, sda_oe, nak;
  logic [7:0] rd, re_cfg, port_val;
  adsp_cfg_a_t cfg_a;
  adsp_cfg_b_t cfg_b;
  adsp_vol_t [NCH-1:0] vol_out;
  int errors = 0;
  int n_tests = 0;
  // Bit 2 of the second register is always written as zero.
  // No reserved decimator or averaging code is ever written to the first register.
  adsp_row_t rows [11] = '{'{8'h6b, 8'h00, 8'h00}, '{8'h6b, 8'h55, 8'h55},
    '{8'h6b, 8'ha6, 8'ha6}, '{8'h6b, 8'h03, 8'h03}, '{8'h6b, 8'h24, 8'h24},
    '{8'h6c, 8'h00, 8'h00}, '{8'h6c, 8'h30, 8'h30}, '{8'h6c, 8'hc2, 8'hc2},
    '{8'h6c, 8'h69, 8'h69}, '{8'h6d, 8'h5a, 8'h5a}, '{8'h6e, 8'hff, 8'h00}};
  logic [7:0] runs [4][4] = '{'{8'h01, 8'h03, 8'h00, 8'h01}, '{8'h09, 8'h00, 8'h03, 8'h01},
    '{8'h0b, 8'h00, 8'h00, 8'h05}, '{8'h08, 8'h00, 8'h03, 8'h00}};
  always #2 clk = ~clk;
  adsp_host_model u_host (.i_ref_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  adsp_config_bank #(.NCH(NCH), .DEV_ADDR(DEV)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_clk_en(ce), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_converter_powered(pwr), .i_per_channel_volume(vol),
    .i_channel_range_enhancer_enable(re_en), .i_gain_above_0db(gain), .o_cfg_a(cfg_a),
    .o_cfg_b(cfg_b), .o_range_enhancer_config(re_cfg), .o_decim_sel(), .o_channel_average_en(),
    .o_hpf_programmable(), .o_hpf_cutoff_sel(), .o_enhanced_algos(), .o_biquad_stage_en(),
    .o_soft_step_en(), .o_compressor_run(), .o_range_enhancer_run(re_run), .o_agc_run(agc_run),
    .o_anti_clip_run(ac_run), .o_volume(vol_out));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic adsp_vol_t exp_vol(input logic [7:0] c);
    exp_vol.mute = (c == 8'h00);
    exp_vol.gain_half_db = $signed({1'b0, c}) - 9'sh0c9;
  endfunction
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(DEV, a, d, nak);
    check("ack", 16'h0000, 16'(nak));
  endtask
  task automatic step;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    u_host.rd(DEV, ADSP_OFS_CFG_A, rd);
    check("cfg_a reset", 16'h0001, 16'(rd));
    u_host.rd(DEV, ADSP_OFS_CFG_B, rd);
    check("cfg_b reset", 16'h0040, 16'(rd));
    check("re_cfg reset", 16'h007b, 16'(re_cfg));
    $display("Test reset values done");
    foreach (rows[i]) begin
      wr_ok(rows[i].a, rows[i].d);
      u_host.rd(DEV, rows[i].a, rd);
      check("readback", 16'(rows[i].rb), 16'(rd));
      port_val = 8'({cfg_a, cfg_b, re_cfg} >> (8 * (ADSP_OFS_RE_CFG - rows[i].a)));
      if (rows[i].a <= ADSP_OFS_RE_CFG) check("port", 16'(rows[i].d), 16'(port_val));
    end
    u_host.wr(DEV ^ 7'h01, ADSP_OFS_RE_CFG, 8'h11, nak);
    check("nak", 16'h0001, 16'(nak));
    check("re_cfg kept", 16'h005a, 16'(re_cfg));
    $display("Test register table done");
    re_en = 4'b0011;
    gain = 4'b0101;
    foreach (runs[i]) begin
      wr_ok(ADSP_OFS_CFG_B, runs[i][0]);
      check("range_enh_run", 16'(runs[i][1]), 16'(re_run));
      check("agc_run", 16'(runs[i][2]), 16'(agc_run));
      check("anti_clip_run", 16'(runs[i][3]), 16'(ac_run));
    end
    $display("Test level modes done");
    wr_ok(ADSP_OFS_CFG_A, 8'h00);
    wr_ok(ADSP_OFS_CFG_B, 8'h00);
    pwr = 1'b1;
    vol = {8'h00, 8'hff, 8'hc9, 8'h01};
    step;
    for (int c = 0; c < 3; c++) check("volume", 16'(exp_vol(vol[c])), 16'(vol_out[c]));
    check("mute", 16'h0001, 16'(vol_out[3].mute));
    wr_ok(ADSP_OFS_CFG_B, 8'h80);
    check("ganged", 16'(exp_vol(8'h01)), 16'(vol_out[3]));
    wr_ok(ADSP_OFS_CFG_A, 8'h80);
    vol[0] = 8'hc9;
    step;
    check("locked", 16'(exp_vol(8'h01)), 16'(vol_out[2]));
    pwr = 1'b0;
    step;
    check("unlocked", 16'(exp_vol(8'hc9)), 16'(vol_out[2]));
    ce = 1'b0;
    vol[0] = 8'hff;
    step;
    check("frozen", 16'(exp_vol(8'hc9)), 16'(vol_out[2]));
    ce = 1'b1;
    step;
    check("resumed", 16'(exp_vol(8'hff)), 16'(vol_out[2]));
    $display("Test volume done");
    rst_n = 1'b0;
    step;
    check("cfg_a", 16'h0001, 16'(cfg_a));
    check("cfg_b", 16'h0040, 16'(cfg_b));
    check("re_cfg", 16'h007b, 16'(re_cfg));
    rst_n = 1'b1;
    step;
    $display("Test mid-run reset done");
    print_verdict;
  end
endmodule
bind adsp_config_bank adsp_config_bank_monitor #(.NCH(NCH)) u_mon (.i_ref_clk, .i_rst_n,
  .i_converter_powered, .i_channel_range_enhancer_enable, .i_gain_above_0db, .o_cfg_a,
  .o_cfg_b, .o_decim_sel, .o_channel_average_en, .o_hpf_programmable, .o_hpf_cutoff_sel,
  .o_enhanced_algos, .o_biquad_stage_en, .o_soft_step_en, .o_compressor_run,
  .o_range_enhancer_run, .o_agc_run, .o_anti_clip_run, .o_volume);
